// [rtl/ltc_pkg.sv]
// Shared constants and types for the per-lane test and error counter bank
package ltc_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int LTC_CNT_W     = 32;   // Every statistics counter
   localparam int LTC_FILL_W    = 10;   // Receive buffer fill level
   localparam int LTC_ADJ_CNT_W = 4;    // Phase adjust step count
   localparam int LTC_DATA_W    = 32;   // Register data word
   localparam int LTC_SEL_W     = 3;    // Register select field of the address
   localparam int LTC_STEP_W    = 2;    // Counter increment per cycle

   // ----------------------------------------------------------------
   // Field positions inside the alignment config word 7
   // ----------------------------------------------------------------
   localparam int LTC_ADJ_CNT_LSB = 0;
   localparam int LTC_ADJ_REQ_BIT = 8;
   localparam int LTC_ADJ_DIR_BIT = 16;

   // ----------------------------------------------------------------
   // Test mode encodings
   // ----------------------------------------------------------------
   localparam logic [2:0] LTC_TM_NORMAL = 3'h0;
   localparam logic [2:0] LTC_TM_COMMA  = 3'h1;   // Continuous comma characters
   localparam logic [2:0] LTC_TM_ILA    = 3'h2;   // Continuous alignment sequences

   // ----------------------------------------------------------------
   // Register selects (low address bits); lane index sits above them
   // ----------------------------------------------------------------
   localparam logic [LTC_SEL_W-1:0] LTC_REG_ALIGN_WORD7 = 3'h0;
   localparam logic [LTC_SEL_W-1:0] LTC_REG_TEST_ERR    = 3'h1;
   localparam logic [LTC_SEL_W-1:0] LTC_REG_LINK_ERR    = 3'h2;
   localparam logic [LTC_SEL_W-1:0] LTC_REG_TEST_SEQ    = 3'h3;
   localparam logic [LTC_SEL_W-1:0] LTC_REG_TEST_MF     = 3'h4;
   localparam logic [LTC_SEL_W-1:0] LTC_REG_FILL_LEVEL  = 3'h5;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   // Subclass 2 phase adjust fields of config word 7
   typedef struct packed {
      logic                     phase_adjust_direction;
      logic                     phase_adjust_request_flag;
      logic [LTC_ADJ_CNT_W-1:0] phase_adjust_step_count;
   } ltc_word7_t;

   localparam ltc_word7_t LTC_WORD7_RST = '{1'b0, 1'b0, 4'h0};

   // Per-lane status delivered by the lane receive logic
   typedef struct packed {
      logic                     cfg_valid;        // Word 7 captured from alignment sequence
      ltc_word7_t               cfg_word7;
      logic                     char_valid;       // One received character this cycle
      logic                     char_is_comma;    // Character is K28.5
      logic                     char_unexpected;  // Character differs from expected sequence
      logic                     disparity_err;
      logic                     not_in_table_err;
      logic                     align_seq_done;   // Complete alignment sequence received
      logic                     align_mf_done;    // Alignment multiframe received
      logic [LTC_FILL_W-1:0]    buf_fill;
   } ltc_lane_in_t;

   // Link error enable tracking, one-hot
   typedef enum logic [1:0] {
      LTC_LE_DISABLED = 2'b01,
      LTC_LE_COUNTING = 2'b10
   } ltc_le_state_t;

endpackage : ltc_pkg

// [rtl/ltc_counter.sv]
// Clearable statistics counter used for every per-lane count
`timescale 1ns/1ns
`default_nettype none

module ltc_counter
#(
   parameter int W = ltc_pkg::LTC_CNT_W
)
(
   input  wire logic                            CLK,
   input  wire logic                            RSTN,
   input  wire logic                            CLR,
   input  wire logic [ltc_pkg::LTC_STEP_W-1:0]  STEP,
   output var  logic [W-1:0]                    COUNT
);
   import ltc_pkg::*;

   logic [W-1:0] count_ff;

   // ----------------------------------------------------------------
   // Count update
   // ----------------------------------------------------------------
   // Clear restarts from this cycle's step, so no event is lost
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
         count_ff <= '0;
      else if (CLR)
         count_ff <= W'(STEP);
      else
         count_ff <= W'(count_ff + W'(STEP));   // Wraps at full scale
   end

   assign COUNT = count_ff;

endmodule // ltc_counter

`default_nettype wire

// [rtl/ltc_lane_counters.sv]
// Per-lane phase adjust fields, test and link error counters, fill level
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// [R1] RX captures 4-bit step count, bits 3:0
// [R2] TX sends programmed step count all lanes
// [R3] Comma test mode: count non-K28.5 characters
// [R4] Alignment test mode: count unexpected characters
// [R5] Test errors clear entering active mode, hold leaving
// [R6] Count disparity and not-in-table errors when enabled
// [R7] Disable then enable clears link error counters
// [R8] Alignment test mode: count complete sequences
// [R9] Sequence count clears entering mode, kept leaving
// [R10] Alignment test mode: count received multiframes
// [R11] Multiframe count clears entering mode, kept leaving
// [R12] Report 10-bit fill level, upper bits zero
// [R13] Application registers all core inputs and outputs
// [R14] Direction bit 16, request bit 8, reset zero
// [R15] Reads never alter counters
module ltc_lane_counters
#(
   parameter int NUM_LANES = 4,
   parameter bit IS_TX     = 1'b0,
   parameter int LANE_W    = (NUM_LANES > 1) ? $clog2(NUM_LANES) : 1
)
(
   input  wire logic                                  CLK,
   input  wire logic                                  RSTN,
   input  wire logic [2:0]                            TEST_MODE,
   input  wire logic                                  LINK_ERR_EN,
   input  wire ltc_pkg::ltc_lane_in_t                 LANE_IN [NUM_LANES],
   input  wire logic                                  REG_RD,
   input  wire logic                                  REG_WR,
   input  wire logic [LANE_W+ltc_pkg::LTC_SEL_W-1:0]  REG_ADDR,
   input  wire logic [ltc_pkg::LTC_DATA_W-1:0]        REG_WDATA,
   output var  logic [ltc_pkg::LTC_DATA_W-1:0]        REG_RDATA,
   output var  logic                                  REG_RVALID,
   output var  ltc_pkg::ltc_word7_t                   TX_ILA_WORD7
);
   import ltc_pkg::*;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // True for the two test modes that drive the counters
   function automatic logic is_active_mode(input logic [2:0] mode);
      is_active_mode = (mode == LTC_TM_COMMA) || (mode == LTC_TM_ILA);
   endfunction

   // True only for continuous alignment sequences
   function automatic logic is_align_mode(input logic [2:0] mode);
      is_align_mode = (mode == LTC_TM_ILA);
   endfunction

   // Places the phase adjust fields at their word positions
   function automatic logic [LTC_DATA_W-1:0] pack_word7(input ltc_word7_t w);
      logic [LTC_DATA_W-1:0] d;
      d = '0;
      d[LTC_ADJ_CNT_LSB +: LTC_ADJ_CNT_W] = w.phase_adjust_step_count;
      d[LTC_ADJ_REQ_BIT]                 = w.phase_adjust_request_flag;
      d[LTC_ADJ_DIR_BIT]                 = w.phase_adjust_direction;
      return d;
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [2:0]              test_mode_ff;
   ltc_le_state_t           le_state_ff;
   ltc_le_state_t           nxt_le_state;
   logic                    le_clr;
   logic                    test_err_clr;
   logic                    align_clr;
   ltc_word7_t              rx_word7_ff [NUM_LANES];
   ltc_word7_t              tx_word7_ff;
   logic [LTC_FILL_W-1:0]   fill_ff     [NUM_LANES];
   logic [LTC_CNT_W-1:0]    test_err_cnt [NUM_LANES];
   logic [LTC_CNT_W-1:0]    link_err_cnt [NUM_LANES];
   logic [LTC_CNT_W-1:0]    test_seq_cnt [NUM_LANES];
   logic [LTC_CNT_W-1:0]    test_mf_cnt  [NUM_LANES];
   logic [LTC_SEL_W-1:0]    rd_sel;
   logic [LANE_W-1:0]       rd_lane;
   logic [LTC_DATA_W-1:0]   nxt_rdata;
   logic [LTC_DATA_W-1:0]   rdata_ff;
   logic                    rvalid_ff;

   assign rd_sel  = REG_ADDR[LTC_SEL_W-1:0];
   assign rd_lane = REG_ADDR[LANE_W+LTC_SEL_W-1:LTC_SEL_W];

   // ----------------------------------------------------------------
   // Test mode transition detection
   // ----------------------------------------------------------------
   // Previous mode, so a change can be seen
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
         test_mode_ff <= LTC_TM_NORMAL;
      else
         test_mode_ff <= TEST_MODE;
   end

   // Leaving a mode clears nothing, so counts stay readable
   // A direct switch between the two active modes also clears errors
   assign test_err_clr = is_active_mode(TEST_MODE) && (TEST_MODE != test_mode_ff);   // [R5]
   assign align_clr    = is_align_mode(TEST_MODE) && !is_align_mode(test_mode_ff);    // [R9] [R11]

   // ----------------------------------------------------------------
   // Link error enable tracking
   // ----------------------------------------------------------------
   // Next state and clear pulse on re-enable
   // Enable already high at reset release also counts as re-enable
   always_comb
   begin
      nxt_le_state = le_state_ff;
      le_clr       = 1'b0;
      unique case (le_state_ff)
         LTC_LE_DISABLED:
         begin
            if (LINK_ERR_EN)
            begin
               nxt_le_state = LTC_LE_COUNTING;
               le_clr       = 1'b1;                // [R7]
            end
         end
         LTC_LE_COUNTING:
         begin
            if (!LINK_ERR_EN)
               nxt_le_state = LTC_LE_DISABLED;
         end
         default:
         begin
            nxt_le_state = LTC_LE_DISABLED;
         end
      endcase
   end

   // State register
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
         le_state_ff <= LTC_LE_DISABLED;
      else
         le_state_ff <= nxt_le_state;
   end

   // ----------------------------------------------------------------
   // Per-lane capture and counters
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_LANES; g++)
   begin : g_lane
      logic [LTC_STEP_W-1:0] test_err_step;
      logic [LTC_STEP_W-1:0] link_err_step;
      logic [LTC_STEP_W-1:0] seq_step;
      logic [LTC_STEP_W-1:0] mf_step;
      logic                  comma_miss;
      logic                  align_miss;

      // Test mode character checks
      // Each check feeds the test error counter only in its own mode
      assign comma_miss = (TEST_MODE == LTC_TM_COMMA) && LANE_IN[g].char_valid
                          && !LANE_IN[g].char_is_comma;                        // [R3]
      assign align_miss = is_align_mode(TEST_MODE) && LANE_IN[g].char_valid
                          && LANE_IN[g].char_unexpected;                       // [R4]

      // Increments; two link errors in one cycle both count
      assign test_err_step = {1'b0, comma_miss | align_miss};
      assign link_err_step = LINK_ERR_EN ? (LTC_STEP_W'(LANE_IN[g].disparity_err)
                                            + LTC_STEP_W'(LANE_IN[g].not_in_table_err))
                                         : '0;                                 // [R6]
      assign seq_step = {1'b0, is_align_mode(TEST_MODE) && LANE_IN[g].align_seq_done};   // [R8]
      assign mf_step  = {1'b0, is_align_mode(TEST_MODE) && LANE_IN[g].align_mf_done};    // [R10]

      // Captured config word 7 in receive configuration
      // Transmit builds never capture, so the array stays at reset
      always_ff @(posedge CLK)
      begin
         if (!RSTN)
            rx_word7_ff[g] <= LTC_WORD7_RST;                                   // [R14]
         else if (!IS_TX && LANE_IN[g].cfg_valid)
            rx_word7_ff[g] <= LANE_IN[g].cfg_word7;                            // [R1]
      end

      // Fill level sampled every cycle
      // One-cycle copy keeps the read mux off the lane logic
      always_ff @(posedge CLK)
      begin
         if (!RSTN)
            fill_ff[g] <= '0;
         else
            fill_ff[g] <= LANE_IN[g].buf_fill;                                 // [R12]
      end

      // Test mode error counter
      ltc_counter #(.W(LTC_CNT_W)) u_test_err
      (
         .CLK   (CLK),
         .RSTN  (RSTN),
         .CLR   (test_err_clr),
         .STEP  (test_err_step),
         .COUNT (test_err_cnt[g])
      );

      // Link error counter
      ltc_counter #(.W(LTC_CNT_W)) u_link_err
      (
         .CLK   (CLK),
         .RSTN  (RSTN),
         .CLR   (le_clr),
         .STEP  (link_err_step),
         .COUNT (link_err_cnt[g])
      );

      // Alignment sequence counter
      ltc_counter #(.W(LTC_CNT_W)) u_test_seq
      (
         .CLK   (CLK),
         .RSTN  (RSTN),
         .CLR   (align_clr),
         .STEP  (seq_step),
         .COUNT (test_seq_cnt[g])
      );

      // Alignment multiframe counter
      ltc_counter #(.W(LTC_CNT_W)) u_test_mf
      (
         .CLK   (CLK),
         .RSTN  (RSTN),
         .CLR   (align_clr),
         .STEP  (mf_step),
         .COUNT (test_mf_cnt[g])
      );
   end

   // ----------------------------------------------------------------
   // Transmit config word 7
   // ----------------------------------------------------------------
   // One programmed value serves every lane
   // Receive builds ignore the write; the word stays at reset
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
         tx_word7_ff <= LTC_WORD7_RST;                                         // [R14]
      else if (IS_TX && REG_WR && (rd_sel == LTC_REG_ALIGN_WORD7))
      begin
         tx_word7_ff.phase_adjust_step_count   <=
            REG_WDATA[LTC_ADJ_CNT_LSB +: LTC_ADJ_CNT_W];                       // [R2]
         tx_word7_ff.phase_adjust_request_flag <= REG_WDATA[LTC_ADJ_REQ_BIT];  // [R14]
         tx_word7_ff.phase_adjust_direction    <= REG_WDATA[LTC_ADJ_DIR_BIT];  // [R14]
      end
   end

   assign TX_ILA_WORD7 = tx_word7_ff;                                          // [R2]

   // ----------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------
   // Pure selection, no side effect on any counter
   // A lane index past NUM_LANES reads zero rather than a stray lane
   always_comb
   begin
      nxt_rdata = '0;
      if (32'(rd_lane) < NUM_LANES)
      begin
         unique case (rd_sel)
            LTC_REG_ALIGN_WORD7: nxt_rdata = IS_TX ? pack_word7(tx_word7_ff)
                                                   : pack_word7(rx_word7_ff[rd_lane]);
            LTC_REG_TEST_ERR:    nxt_rdata = test_err_cnt[rd_lane];           // [R15]
            LTC_REG_LINK_ERR:    nxt_rdata = link_err_cnt[rd_lane];           // [R15]
            LTC_REG_TEST_SEQ:    nxt_rdata = test_seq_cnt[rd_lane];           // [R15]
            LTC_REG_TEST_MF:     nxt_rdata = test_mf_cnt[rd_lane];            // [R15]
            LTC_REG_FILL_LEVEL:  nxt_rdata = {{(LTC_DATA_W-LTC_FILL_W){1'b0}},
                                              fill_ff[rd_lane]};              // [R12]
            default:             nxt_rdata = '0;   // Unmapped select reads zero
         endcase
      end
   end

   // Read data and its one-cycle valid
   // Data holds between reads so software may sample it late
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         rdata_ff  <= '0;
         rvalid_ff <= 1'b0;
      end
      else
      begin
         rvalid_ff <= REG_RD;
         if (REG_RD)
            rdata_ff <= nxt_rdata;
      end
   end

   assign REG_RDATA  = rdata_ff;
   assign REG_RVALID = rvalid_ff;

endmodule // ltc_lane_counters

`default_nettype wire

// [tb/ltc_lane_counters_properties.sv]
// Concurrent checks on the ports of the lane counter register bank
`timescale 1ns/1ns
`default_nettype none

module ltc_lane_counters_properties
   import ltc_pkg::*;
#(
   parameter int NUM_LANES = 4,
   parameter bit IS_TX     = 1'b0,
   parameter int LANE_W    = 2
)
(
   input wire logic                                  CLK,
   input wire logic                                  RSTN,
   input wire logic [2:0]                            TEST_MODE,
   input wire logic                                  LINK_ERR_EN,
   input wire ltc_pkg::ltc_lane_in_t                 LANE_IN [NUM_LANES],
   input wire logic                                  REG_RD,
   input wire logic                                  REG_WR,
   input wire logic [LANE_W+ltc_pkg::LTC_SEL_W-1:0]  REG_ADDR,
   input wire logic [ltc_pkg::LTC_DATA_W-1:0]        REG_WDATA,
   input wire logic [ltc_pkg::LTC_DATA_W-1:0]        REG_RDATA,
   input wire logic                                  REG_RVALID,
   input wire ltc_pkg::ltc_word7_t                   TX_ILA_WORD7
);
   ltc_word7_t            cfg0_ff;
   logic [LTC_FILL_W-1:0] fill0_ff;
   logic [LTC_SEL_W-1:0]  sel;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   assign sel = REG_ADDR[LTC_SEL_W-1:0];

   // Lane 0 captured word and fill copy
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         cfg0_ff  <= LTC_WORD7_RST;
         fill0_ff <= '0;
      end
      else
      begin
         if (LANE_IN[0].cfg_valid)
            cfg0_ff <= LANE_IN[0].cfg_word7;
         fill0_ff <= LANE_IN[0].buf_fill;
      end
   end

   // ----------------------------------------------------------------
   // Register port timing and contents
   // ----------------------------------------------------------------
   chk_rvalid_after_read: assert property (REG_RD |=> REG_RVALID)
      else $error("read not answered next cycle");
   chk_rvalid_no_read: assert property (!REG_RD |=> !REG_RVALID)
      else $error("answer without read");
   chk_rdata_held: assert property (!REG_RD |=> $stable(REG_RDATA))
      else $error("read data changed without read");
   chk_word7_capture: assert property (REG_RD && REG_ADDR == '0 && !LANE_IN[0].cfg_valid && !IS_TX |=>
      REG_RDATA == {15'h0, cfg0_ff.phase_adjust_direction, 7'h0, cfg0_ff.phase_adjust_request_flag,
                    4'h0, cfg0_ff.phase_adjust_step_count})
      else $error("captured word 7 fields wrong");
   chk_fill_level: assert property (REG_RD && REG_ADDR == (LANE_W+LTC_SEL_W)'(LTC_REG_FILL_LEVEL) |=>
      REG_RDATA[9:0] == $past(fill0_ff))
      else $error("fill level wrong");
   chk_fill_upper_zero: assert property (REG_RD && sel == LTC_REG_FILL_LEVEL |=> REG_RDATA[31:10] == '0)
      else $error("fill level upper bits set");
   chk_bad_sel_zero: assert property (REG_RD && sel > LTC_REG_FILL_LEVEL |=> REG_RDATA == '0)
      else $error("unused select not zero");
   chk_tx_word_idle: assert property (REG_WR |=> IS_TX || TX_ILA_WORD7 == LTC_WORD7_RST)
      else $error("transmit word set in receive build");
endmodule // ltc_lane_counters_properties

bind ltc_lane_counters ltc_lane_counters_properties
   #(.NUM_LANES(NUM_LANES), .IS_TX(IS_TX), .LANE_W(LANE_W)) i_ltc_lane_counters_properties
   (.CLK(CLK), .RSTN(RSTN), .TEST_MODE(TEST_MODE), .LINK_ERR_EN(LINK_ERR_EN), .LANE_IN(LANE_IN),
    .REG_RD(REG_RD), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .TX_ILA_WORD7(TX_ILA_WORD7));

`default_nettype wire

// [tb/ltc_lane_counters_tb.sv]
// Self-checking bench for the lane counter register bank
`timescale 1ns/1ns
`default_nettype none

module ltc_lane_counters_tb;
   import ltc_pkg::*;
   logic         clk, rstn, rd, wr, le_en, rvalid;
   logic [2:0]   mode;
   logic [4:0]   addr;
   logic [31:0]  wdata, rdata;
   ltc_word7_t   tx_w7;
   ltc_lane_in_t lin [4];
   logic [31:0]  exp_q [$];
   logic [31:0]  seed = 32'h0001774C;
   int           bad_count = 0, tests_run = 0, cycles = 0;

   ltc_lane_counters #(.NUM_LANES(4), .IS_TX(1'b0)) i_ltc_lane_counters
     (.CLK(clk), .RSTN(rstn), .TEST_MODE(mode), .LINK_ERR_EN(le_en), .LANE_IN(lin), .REG_RD(rd),
      .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
      .TX_ILA_WORD7(tx_w7));

   // Clock, 40 ns period
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(string nm, logic [31:0] seen, logic [31:0] ex);
      tests_run++;
      if (seen !== ex)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Read request, expectation noted in the queue
   task automatic rd_exp(logic [4:0] a, logic [31:0] e);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask

   // One-cycle lane event, fill level kept; all inputs from flops
   task automatic ev(int l, ltc_lane_in_t v);
      ltc_lane_in_t z;
      z = '0;
      z.buf_fill = lin[l].buf_fill;
      v.buf_fill = z.buf_fill;
      @(posedge clk);
      lin[l] <= v;
      @(posedge clk);
      lin[l] <= z;
   endtask

   task automatic set_mode(logic [2:0] m);
      @(posedge clk);
      mode <= m;
   endtask

   // Returned words against the oldest expectation
   always @(posedge clk)
   begin
      if (rvalid === 1'b1)
         check("rdata", rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 32'hXXXXXXXX);
   end

   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         bad_count++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      ltc_lane_in_t v;
      int           n, e1, e2, e3;
      rstn = 1'b0; rd = 1'b0; wr = 1'b0; le_en = 1'b0;
      mode = 3'h0; addr = 5'h00; wdata = 32'h0;
      foreach (lin[i]) lin[i] = '0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      for (int s = 0; s < 8; s++)
         rd_exp(s[4:0], 32'h0);
      // Captured word 7, then a write that must be ignored
      seed = lfsr(seed);
      v = '0;
      v.cfg_valid = 1'b1;
      v.cfg_word7 = seed[5:0];
      ev(0, v);
      @(posedge clk);
      wr    <= 1'b1;
      wdata <= 32'hFFFFFFFF;
      addr  <= 5'h00;
      @(posedge clk);
      wr <= 1'b0;
      rd_exp(5'h00, {15'h0, seed[5], 7'h0, seed[4], 4'h0, seed[3:0]});
      check("tx_word7", {26'h0, tx_w7}, 32'h0);
      // Alignment test mode counts, held after exit
      set_mode(LTC_TM_ILA);
      n = int'(seed[8:6]) + 3;
      e1 = 0; e2 = 0; e3 = 0;
      for (int i = 0; i < n; i++)
      begin
         v = '0;
         v.char_valid = 1'b1;
         v.char_unexpected = i[0];
         v.align_seq_done = i[1];
         v.align_mf_done = 1'b1;
         ev(2, v);
         e1 += i[0]; e2 += i[1]; e3++;
      end
      set_mode(LTC_TM_NORMAL);
      ev(2, '1);
      rd_exp({2'h2, LTC_REG_TEST_ERR}, e1);
      rd_exp({2'h2, LTC_REG_TEST_SEQ}, e2);
      rd_exp({2'h2, LTC_REG_TEST_MF}, e3);
      rd_exp({2'h2, LTC_REG_TEST_MF}, e3);
      // Comma test mode clears and counts non-comma characters
      set_mode(LTC_TM_COMMA);
      e1 = 0;
      for (int i = 0; i < n; i++)
      begin
         v = '0;
         v.char_valid = 1'b1;
         v.char_is_comma = i[0];
         v.align_seq_done = 1'b1;
         ev(2, v);
         e1 += !i[0];
      end
      rd_exp({2'h2, LTC_REG_TEST_ERR}, e1);
      rd_exp({2'h2, LTC_REG_TEST_SEQ}, e2);
      set_mode(LTC_TM_ILA);
      for (int s = 1; s < 5; s++)
         rd_exp({2'h2, s[2:0]}, 32'h0);
      set_mode(LTC_TM_NORMAL);
      // Link errors, hold while disabled, clear on re-enable
      @(posedge clk);
      le_en <= 1'b1;
      e1 = 0;
      for (int i = 0; i < n; i++)
      begin
         v = '0;
         v.disparity_err = 1'b1;
         v.not_in_table_err = i[0];
         ev(0, v);
         e1 += 1 + i[0];
      end
      @(posedge clk);
      le_en <= 1'b0;
      ev(0, '1);
      rd_exp({2'h0, LTC_REG_LINK_ERR}, e1);
      @(posedge clk);
      le_en <= 1'b1;
      rd_exp({2'h0, LTC_REG_LINK_ERR}, 32'h0);
      // Fill levels
      seed = lfsr(seed);
      lin[3].buf_fill <= seed[9:0];
      lin[0].buf_fill <= seed[19:10];
      rd_exp({2'h3, LTC_REG_FILL_LEVEL}, {22'h0, seed[9:0]});
      rd_exp({2'h0, LTC_REG_FILL_LEVEL}, {22'h0, seed[19:10]});
      repeat (4) @(posedge clk);
      check("pending", exp_q.size(), 32'h0);
      end_of_test();
   end
endmodule // ltc_lane_counters_tb

`default_nettype wire
